// [logic/idpc_pkg.sv]
// constants, types and register map of the idle and doze power control
package idpc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;

   // register byte addresses
   localparam logic [11:0] REGULATOR_POWER_CONTROL_ADDR = 12'h000;
   localparam logic [11:0] DOZE_IDLE_CONTROL_ADDR = 12'h004;

   ////////////////////////////////////////////////////////////////////////
   // regulator_power_control fields
   localparam int REGULATOR_LOW_POWER_BIT = 1;
   localparam int REG_FIXED_ONE_BIT = 0;
   localparam logic REGULATOR_LOW_POWER_RST = 1'b0;

   // doze_idle_control fields
   localparam int IDLE_SELECT_BIT = 7;
   localparam int CPU_SLOW_ENABLE_BIT = 6;
   localparam int WAKE_RESTORES_SPEED_BIT = 5;
   localparam int SLOW_ON_RETURN_BIT = 4;
   localparam int CPU_CYCLE_RATIO_LSB = 0;
   localparam int CPU_CYCLE_RATIO_W = 3;
   localparam logic IDLE_SELECT_RST = 1'b0;
   localparam logic CPU_SLOW_ENABLE_RST = 1'b0;
   localparam logic WAKE_RESTORES_SPEED_RST = 1'b0;
   localparam logic SLOW_ON_RETURN_RST = 1'b0;
   localparam logic [2:0] CPU_CYCLE_RATIO_RST = 3'h0;

   // doze counter width, enough for the 1:256 ratio
   localparam int DOZE_CNT_W = 8;

   ////////////////////////////////////////////////////////////////////////
   // power state, one-hot
   typedef enum logic [2:0] {
      IDPC_RUN = 3'b001,
      IDPC_IDLE = 3'b010,
      IDPC_SLEEP = 3'b100
   } idpc_state_e;

   // events and levels from the processor core side
   typedef struct packed {
      logic sleep_exec;    // pulse: sleep instruction executed
      logic irq_pending;   // level: an enabled interrupt flag is set
      logic irq_entry;     // pulse: interrupt service routine entered
      logic irq_return;    // pulse: return_from_irq executed
      logic wdt_timeout;   // pulse: watchdog_timer timeout
      logic debug_active;  // level: in_circuit_debug running
      logic periph_cycle;  // pulse: one peripheral instruction cycle
      logic sleep_wake;    // pulse: full sleep wake from outside logic
   } idpc_core_in_s;

   // power controls toward the rest of the chip
   typedef struct packed {
      logic cpu_cycle_en;     // pulse: CPU may run one instruction cycle
      logic flash_en;         // level: program_flash may operate
      logic idle_active;      // level: device is in Idle
      logic sleep_active;     // level: device is in full sleep
      logic sysosc_periph_en; // level: system_osc peripheral clocks run
      logic other_osc_periph_en; // level: other oscillator peripherals
      logic clock_output_pin_en;        // level: clock_output_pin driven
      logic regulator_lp;     // level: regulator in low-power state
      logic wdt_reset_req;    // pulse: watchdog reset passed on
   } idpc_pwr_out_s;

endpackage : idpc_pkg

// [logic/idpc_doze_div.sv]
// peripheral cycle divider that paces CPU cycles while dozing
`timescale 1ns/1ps
`default_nettype none

module idpc_doze_div #(
   parameter int CNT_W = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic restart,
   input wire logic tick,
   input wire logic [2:0] ratio,
   // result
   output logic hit
);

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] last;
   logic [CNT_W-1:0] next_cnt;

   ////////////////////////////////////////////////////////////////////////
   // last count is 2^(ratio+1)-1: code 0 gives 1:2, code 7 gives 1:256
   assign last = CNT_W'((2 << ratio) - 1);
   assign hit = tick && (cnt == last);
   assign next_cnt = restart ? '0 :
                     hit ? '0 :
                     tick ? cnt + 1'b1 : cnt;

   // count peripheral cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

endmodule : idpc_doze_div

`default_nettype wire

// [logic/idpc_top.sv]
// idle, doze and regulator power control with an APB register port
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module idpc_top (
   // clock and resets
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [idpc_pkg::ADDR_W-1:0] paddr,
   input wire logic [idpc_pkg::DATA_W-1:0] pwdata,
   output logic [idpc_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // configuration
   input wire logic clock_output_pin_cfg_n,
   // processor core, interrupt and watchdog side
   input wire idpc_pkg::idpc_core_in_s core_in,
   // power controls
   output idpc_pkg::idpc_pwr_out_s pwr_out
);

   import idpc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // declarations
   idpc_state_e state;
   idpc_state_e next_state;
   logic regulator_low_power;
   logic idle_select;
   logic cpu_slow_enable;
   logic wake_restores_speed;
   logic slow_on_return;
   logic [2:0] cpu_cycle_ratio;
   logic next_cpu_slow_enable;
   logic slow_prev;
   logic doze_restart;
   logic doze_hit;
   logic slow_effective;
   logic idle_irq_wake;
   logic idle_wdt_wake;
   logic sleep_taken;
   logic bus_setup;
   logic bus_done;
   logic wr_done;
   logic sel_reg;
   logic sel_doze;
   logic addr_hit;
   logic wr_reg;
   logic wr_doze;
   logic [REG_W-1:0] reg_rd;
   logic [REG_W-1:0] doze_rd;
   logic [REG_W-1:0] rd_mux;
   logic [REG_W-1:0] wbyte;
   idpc_pwr_out_s next_pwr;

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   assign bus_setup = psel && !penable;
   assign bus_done = psel && penable && pready;
   assign wr_done = bus_done && pwrite;
   assign sel_reg = (paddr == REGULATOR_POWER_CONTROL_ADDR);
   assign sel_doze = (paddr == DOZE_IDLE_CONTROL_ADDR);
   assign addr_hit = sel_reg || sel_doze;
   assign wr_reg = wr_done && sel_reg;
   assign wr_doze = wr_done && sel_doze;
   assign wbyte = pwdata[REG_W-1:0];

   // read views of both registers
   // bit 0 reads one, bit 1 the low-power select, bits 7:2 zero
   assign reg_rd = {6'h00, regulator_low_power, 1'b1};
   assign doze_rd = {idle_select, cpu_slow_enable, wake_restores_speed,
                     slow_on_return, 1'b0, cpu_cycle_ratio};
   assign rd_mux = sel_reg ? reg_rd :
                   sel_doze ? doze_rd : 8'h00;

   // answer: ready in the cycle after setup, data and error with it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= bus_setup;
         pslverr <= bus_setup && !addr_hit;
         prdata <= (bus_setup && !pwrite) ? {24'h00_0000, rd_mux}
                                          : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // regulator control
   // low-power regulator select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regulator_low_power <= REGULATOR_LOW_POWER_RST;
      end else if (wr_reg) begin
         regulator_low_power <= wbyte[REGULATOR_LOW_POWER_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // idle_select lives on the power-on and brown-out reset only
   // kept across other resets
   always_ff @(posedge pclk or negedge por_resetn) begin
      if (!por_resetn) begin
         idle_select <= IDLE_SELECT_RST;
      end else if (wr_doze) begin
         idle_select <= wbyte[IDLE_SELECT_BIT];
      end
   end

   // plain control fields of the doze register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_restores_speed <= WAKE_RESTORES_SPEED_RST;
         slow_on_return <= SLOW_ON_RETURN_RST;
         cpu_cycle_ratio <= CPU_CYCLE_RATIO_RST;
      end else if (wr_doze) begin
         wake_restores_speed <= wbyte[WAKE_RESTORES_SPEED_BIT];
         slow_on_return <= wbyte[SLOW_ON_RETURN_BIT];
         cpu_cycle_ratio <= wbyte[CPU_CYCLE_RATIO_LSB +: CPU_CYCLE_RATIO_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // wake causes while in Idle
   // wake regardless of enable
   assign idle_irq_wake = (state == IDPC_IDLE) && core_in.irq_pending;
   assign idle_wdt_wake = (state == IDPC_IDLE) && core_in.wdt_timeout
                          && !core_in.irq_pending;
   // sleep instruction with a pending interrupt acts as a no-op
   assign sleep_taken = (state == IDPC_RUN) && core_in.sleep_exec
                        && !core_in.irq_pending;

   // cpu_slow_enable: software write, then hardware edits win
   always_comb begin
      next_cpu_slow_enable = cpu_slow_enable;
      if (wr_doze) begin
         next_cpu_slow_enable = wbyte[CPU_SLOW_ENABLE_BIT];
      end
      if (core_in.irq_return && slow_on_return) begin
         next_cpu_slow_enable = 1'b1;
      end
      if (core_in.irq_entry && wake_restores_speed) begin
         next_cpu_slow_enable = 1'b0;
      end
      if (idle_irq_wake && wake_restores_speed) begin
         next_cpu_slow_enable = 1'b0;
      end
   end

   // stored doze enable, hardware set and clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_slow_enable <= CPU_SLOW_ENABLE_RST;
         slow_prev <= CPU_SLOW_ENABLE_RST;
      end else begin
         cpu_slow_enable <= next_cpu_slow_enable;
         slow_prev <= cpu_slow_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power state machine
   always_comb begin
      case (state)
         IDPC_RUN: begin
            if (sleep_taken) begin
               next_state = idle_select ? IDPC_IDLE : IDPC_SLEEP;
            end else begin
               next_state = IDPC_RUN;
            end
         end
         IDPC_IDLE: begin
            if (idle_irq_wake || idle_wdt_wake) begin
               next_state = IDPC_RUN;
            end else begin
               next_state = IDPC_IDLE;
            end
         end
         IDPC_SLEEP: begin
            next_state = core_in.sleep_wake ? IDPC_RUN : IDPC_SLEEP;
         end
         default: begin
            next_state = IDPC_RUN;
         end
      endcase
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= IDPC_RUN;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // doze pacing
   // debug forces full speed
   assign slow_effective = cpu_slow_enable && !core_in.debug_active;
   assign doze_restart = (cpu_slow_enable != slow_prev) || !slow_effective;

   idpc_doze_div #(
      .CNT_W(DOZE_CNT_W)
   ) u_doze_div (
      .pclk(pclk),
      .presetn(presetn),
      .restart(doze_restart),
      .tick(core_in.periph_cycle),
      .ratio(cpu_cycle_ratio),
      .hit(doze_hit)
   );

   ////////////////////////////////////////////////////////////////////////
   // next power outputs
   always_comb begin
      next_pwr = '0;
      next_pwr.cpu_cycle_en = (next_state == IDPC_RUN) && (state == IDPC_RUN)
                              && core_in.periph_cycle
                              && (slow_effective ? doze_hit : 1'b1);
      next_pwr.flash_en = (next_state == IDPC_RUN);
      next_pwr.idle_active = (next_state == IDPC_IDLE);
      next_pwr.sleep_active = (next_state == IDPC_SLEEP);
      next_pwr.sysosc_periph_en = (next_state != IDPC_SLEEP);
      next_pwr.other_osc_periph_en = 1'b1;
      next_pwr.clock_output_pin_en = !clock_output_pin_cfg_n && (next_state != IDPC_SLEEP);
      next_pwr.regulator_lp = regulator_low_power
                              && (next_state == IDPC_SLEEP);
      next_pwr.wdt_reset_req = core_in.wdt_timeout && (state == IDPC_RUN);
   end

   // registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_out <= '0;
      end else begin
         pwr_out <= next_pwr;
      end
   end

endmodule : idpc_top

`default_nettype wire

// [verification/idpc_sva.sv]
// port checker for idle, sleep, doze and bus timing
`timescale 1ns/1ps
`default_nettype none
module idpc_sva (
   // clock, resets and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [idpc_pkg::ADDR_W-1:0] paddr,
   input wire logic [idpc_pkg::DATA_W-1:0] pwdata,
   input wire logic [idpc_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // configuration, core side, power controls
   input wire logic clock_output_pin_cfg_n,
   input wire idpc_pkg::idpc_core_in_s core_in,
   input wire idpc_pkg::idpc_pwr_out_s pwr_out
);
   import idpc_pkg::*;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // state and bus decodes
   wire run = pwr_out.flash_en;
   wire idle = pwr_out.idle_active;
   wire setup = psel && !penable;
   wire mapped = paddr == 12'h000 || paddr == 12'h004;
   a_bus_answer: assert property (setup |=> pready ##1 !pready)
      else $error("bus answer");
   a_unmapped_err: assert property (
      setup && !mapped |=> pslverr && prdata == 32'h0)
      else $error("unmapped not refused");
   a_sleep_entry: assert property (
      run && core_in.sleep_exec && !core_in.irq_pending
      |=> !run && (idle != pwr_out.sleep_active))
      else $error("sleep entry");
   a_idle_halts: assert property (idle |-> !run &&
      !pwr_out.cpu_cycle_en && pwr_out.sysosc_periph_en)
      else $error("idle halt");
   a_sleep_clocks: assert property (pwr_out.sleep_active |->
      !pwr_out.sysosc_periph_en && pwr_out.other_osc_periph_en)
      else $error("sleep clocks");
   a_clock_output_pin_idle: assert property (
      idle |-> pwr_out.clock_output_pin_en == !clock_output_pin_cfg_n)
      else $error("clock output in idle");
   a_irq_wakes: assert property (
      idle && core_in.irq_pending |=> run && !idle)
      else $error("irq wake");
   a_wdt_wakes: assert property (
      idle && core_in.wdt_timeout |=> run && !pwr_out.wdt_reset_req)
      else $error("watchdog wake");
   a_lp_sleep: assert property (
      pwr_out.regulator_lp |-> pwr_out.sleep_active)
      else $error("regulator outside sleep");
   a_debug_speed: assert property (
      core_in.debug_active && core_in.periph_cycle && run &&
      !core_in.sleep_exec |=> pwr_out.cpu_cycle_en)
      else $error("debug speed");
   c_idle: cover property (idle && core_in.irq_pending);
   c_sleep: cover property (pwr_out.sleep_active && core_in.sleep_wake);
   c_doze: cover property (pwr_out.cpu_cycle_en && !core_in.debug_active);
endmodule : idpc_sva
bind idpc_top idpc_sva chk_u (.pclk(pclk), .presetn(presetn),
   .por_resetn(por_resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .clock_output_pin_cfg_n(clock_output_pin_cfg_n),
   .core_in(core_in), .pwr_out(pwr_out));
`default_nettype wire

// [verification/idpc_core_model.sv]
// processor core stand-in: passes events, paces peripheral cycles
`timescale 1ns/1ps
`default_nettype none
module idpc_core_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench commands
   input wire idpc_pkg::idpc_core_in_s cmd,
   input wire logic gen_en,
   input wire logic slow,
   // toward the power control
   output idpc_pkg::idpc_core_in_s core_in
);
   import idpc_pkg::*;
   logic [1:0] div;
   // slow mode gives one peripheral cycle in four clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div <= 2'h0;
      end else begin
         div <= div + 2'h1;
      end
   end
   // events pass through; peripheral cycles come from here
   always_comb begin
      core_in = cmd;
      core_in.periph_cycle = gen_en && !(slow && div != 2'h0);
   end
endmodule : idpc_core_model
`default_nettype wire

// [verification/idpc_top_tb.sv]
// bench: register, doze, idle and sleep scenarios against a model
`timescale 1ns/1ps
`default_nettype none
module idpc_top_tb;
   import idpc_pkg::*;
   localparam logic [7:0] SLP = 8'h80, IRQ = 8'h40, ENT = 8'h20;
   localparam logic [7:0] RET = 8'h10, WDT = 8'h08, WAKE = 8'h01;
   logic pclk, presetn, por_resetn, psel, penable, pwrite, er;
   logic pready, pslverr, clock_output_pin_cfg_n, gen_en, slow;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   idpc_core_in_s cmd, core_in;
   idpc_pwr_out_s pwr_out;
   int err_count, checks, pcnt, ccnt, mdoze, mreg, d;
   int seed = 32'hABBE;
   idpc_top dut_u (.pclk(pclk), .presetn(presetn), .por_resetn(por_resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .clock_output_pin_cfg_n(clock_output_pin_cfg_n), .core_in(core_in), .pwr_out(pwr_out));
   idpc_core_model core_u (.pclk(pclk), .presetn(presetn), .cmd(cmd),
      .gen_en(gen_en), .slow(slow), .core_in(core_in));
   // clock and settled-value cycle counters
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(negedge pclk) begin
      pcnt += core_in.periph_cycle;
      ccnt += pwr_out.cpu_cycle_en;
   end
   ////////////////////////////////////////////////////////////////////
   task final_report;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   task cmp_v(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : cmp_v
   task cmp_b(input string nm, input logic e, input logic g);
      cmp_v(nm, {31'h0, e}, {31'h0, g});
   endtask : cmp_b
   task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      if (n == 20) err_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task wr(input logic [11:0] a, input int v);
      apb(1'b1, a, v);
      if (a == 12'h004) mdoze = v & 'hF7;
      if (a == 12'h000) mreg = (v & 2) | 1;
   endtask : wr
   task rdchk(input logic [11:0] a, input int e);
      apb(1'b0, a, 32'h0);
      cmp_v("prdata", e, rd);
      cmp_b("pslverr", a != 12'h000 && a != 12'h004, er);
   endtask : rdchk
   task ev(input idpc_core_in_s e);
      cmd <= cmd | e;
      @(posedge pclk);
      cmd <= cmd & ~e;
      @(posedge pclk);
   endtask : ev
   task rst(input logic por);
      presetn <= 1'b0;
      por_resetn <= !por;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      por_resetn <= 1'b1;
      @(posedge pclk);
      mdoze = por ? 0 : mdoze & 'h80;
      mreg = 1;
   endtask : rst
   task doze(input int v, input logic dbg, input int n);
      wr(12'h004, 0);
      wr(12'h004, v);
      cmd.debug_active <= dbg;
      slow <= 1'($random(seed));
      gen_en <= 1'b1;
      pcnt = 0;
      ccnt = 0;
      while (pcnt < n) @(posedge pclk);
      gen_en <= 1'b0;
      cmd.debug_active <= 1'b0;
      repeat (2) @(posedge pclk);
      cmp_v("cpu cycles", (v & 'h40) && !dbg ? n >> (v % 8 + 1) : n,
            ccnt);
   endtask : doze
   task step(input int v, input logic [7:0] e);
      wr(12'h004, v);
      if (v & 'h80) begin
         ev(SLP);
         cmp_b("idle", 1'b1, pwr_out.idle_active); // idle entry
         cmp_b("flash", 1'b0, pwr_out.flash_en); // halted
         cmp_b("clock_output_pin", !clock_output_pin_cfg_n, pwr_out.clock_output_pin_en); // kept
      end
      ev(e);
      cmp_b("idle", 1'b0, pwr_out.idle_active); // woken
      d = e == WDT && !(v & 'h80);
      cmp_b("wdt reset", d[0], pwr_out.wdt_reset_req); // reset only for a watchdog timeout outside Idle
      if ((e == IRQ || e == ENT) && (v & 'h20)) mdoze &= 'hBF;
      if (e == RET && (v & 'h10)) mdoze |= 'h40;
      rdchk(12'h004, mdoze); // select kept
   endtask : step
   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {presetn, por_resetn, psel, penable, pwrite, gen_en, slow} = '0;
      paddr = '0;
      pwdata = '0;
      cmd = '0;
      clock_output_pin_cfg_n = 1'($random(seed));
      rst(1'b1);
      rdchk(12'h000, 1); // fixed one
      rdchk(12'h004, 0); // cleared
      rdchk(12'h008, 0); // unmapped
      repeat (4) begin
         d = $random(seed);
         wr(12'h000, d | 1); // kept set
         rdchk(12'h000, mreg); // low power bit
         wr(12'h004, d);
         rdchk(12'h004, mdoze); // doze bits
      end
      wr(12'h004, 'h80);
      rst(1'b0);
      rdchk(12'h004, mdoze); // kept
      rst(1'b1);
      rdchk(12'h004, mdoze); // power-on clear
      for (int r = 0; r < 8; r++) doze('h40 | r, 1'b0, 2 << (r + 1));
      doze('h07, 1'b0, 16); // full rate
      doze('h47, 1'b1, 16); // debug speed
      rdchk(12'h004, mdoze); // bit kept
      step('hE3, IRQ); // wake restores
      ev(SLP);
      cmp_b("idle", 1'b1, pwr_out.idle_active); // reentry
      ev(IRQ);
      step('hC3, WDT); // watchdog wake
      step('hC3, IRQ); // still dozing
      step('h63, ENT); // entry clears
      step('h43, ENT); // entry keeps
      step('h13, RET); // return sets
      step('h03, RET); // return keeps
      step('h03, WDT); // reset outside Idle
      wr(12'h000, 'h03);
      wr(12'h004, 0);
      ev(SLP);
      cmp_b("sleep", 1'b1, pwr_out.sleep_active); // full sleep
      cmp_b("sysosc", 1'b0, pwr_out.sysosc_periph_en); // stopped
      cmp_b("other", 1'b1, pwr_out.other_osc_periph_en); // running
      cmp_b("regulator", 1'b1, pwr_out.regulator_lp); // low power
      ev(WAKE);
      cmp_b("regulator", 1'b0, pwr_out.regulator_lp); // normal
      final_report();
   end
   // hang guard
   initial begin
      #(8 * 40000);
      err_count++;
      final_report();
   end
endmodule : idpc_top_tb
`default_nettype wire
